//--- hdl/pas_consts.svh
// constants, field positions and register map of the power accumulator sequencer
`ifndef PAS_CONSTS_SVH
`define PAS_CONSTS_SVH
// Functional notes
// RULE1 - samples kept 17-bit signed, two's complement math
// RULE2 - power is shunt times rail top 14 bits
// RULE3 - unipolar results read as 16 unsigned bits
// RULE4 - bipolar rail reads as 16-bit signed truncation
// RULE5 - bipolar shunt truncated, power keeps 17 bits
// RULE6 - half range shifts bits, power keeps precision
// RULE7 - 32-bit sample counter never auto-cleared
// RULE8 - accumulators saturate, never wrap
// RULE9 - fullness thresholds 15/16, 7/8, 3/4, full
// RULE10 - 56-bit accumulator sums 30-bit products
// RULE11 - per channel select power, shunt or rail
// RULE12 - after each conversion accumulate and count
// RULE13 - eight-sample averages updated every cycle
// RULE14 - cycle: active channels, offset slot, sleep
// RULE15 - channels disableable; none enabled means sleep
// RULE16 - burst: no sleep, no offset slot
// RULE17 - fast: no sleep, offset slot kept
// RULE18 - single shot: snapshot starts one cycle, sleep
// RULE19 - host spaces snapshot commands by milliseconds
// RULE20 - single 8X: eight samples per snapshot
// RULE21 - 8X leaves average and last sample readable
// RULE22 - alerts latch low at cycle end; 5 us pulse
`define PAS_CLK_HZ 25000000
`define PAS_SLOT_SPS 5120
`define PAS_SLOT_CYC (`PAS_CLK_HZ / `PAS_SLOT_SPS)
`define PAS_SLOTS_PER_CYCLE 5
`define PAS_PERIOD_CYC (`PAS_SLOT_CYC * `PAS_SLOTS_PER_CYCLE)
`define PAS_CC_PULSE_NS 5000
`define PAS_CC_CYC ((`PAS_CC_PULSE_NS * (`PAS_CLK_HZ / 1000000) + 999) / 1000)
`define PAS_CTRL_ADDR 12'h000
`define PAS_ACCCFG_ADDR 12'h004
`define PAS_CMD_ADDR 12'h008
`define PAS_STATUS_ADDR 12'h00C
`define PAS_CTRL_RST 32'h000000F0
`define PAS_CTRL_MODE_LSB 0
`define PAS_CTRL_CHEN_LSB 4
`define PAS_CTRL_RAILBIP_BIT 8
`define PAS_CTRL_SHUNTBIP_BIT 9
`define PAS_CTRL_HALF_BIT 10
`define PAS_CTRL_CCEN_BIT 11
`define PAS_ACCCFG_THR_LSB 8
`define PAS_CMD_SNAP_BIT 0
`define PAS_CH_FIRST 7'h01
`define PAS_CH_LAST 7'h04
`define PAS_OFFSET_CHAN 3'h4
`define PAS_DONE_CHAN 3'h5
`define PAS_SHOTS_8X 4'h8
`endif

//--- hdl/pas_pkg.sv
// types shared by the power accumulator sequencer
`default_nettype none
package pas_pkg;
	typedef enum logic [2:0] {PAS_CONT, PAS_BURST, PAS_FAST, PAS_SINGLE, PAS_SINGLE8} pas_mode_t;
	typedef enum logic [1:0] {PAS_SLEEP, PAS_START, PAS_WAIT, PAS_PAD} pas_seq_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pas_apb_req_t;
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} pas_apb_rsp_t;
	typedef struct packed {
		logic start;
		logic [2:0] chan;
	} pas_conv_req_t;
	typedef struct packed {
		logic done;
		logic [16:0] rail;
		logic [16:0] shunt;
	} pas_conv_rsp_t;
	typedef struct packed {
		pas_mode_t mode;
		logic [3:0] chan_en;
		logic rail_bip;
		logic shunt_bip;
		logic half_range_mode;
		logic cc_en;
		logic [3:0][1:0] acc_sel;
		logic [3:0][1:0] fill_thr;
		pas_seq_t seq;
		logic [2:0] chan;
		logic [31:0] period_cnt;
		logic [3:0] shots;
		logic [16:0] off_rail;
		logic [16:0] off_shunt;
		logic [3:0][16:0] rail_voltage_sample;
		logic [3:0][16:0] shunt_voltage_sample;
		logic [3:0][7:0][16:0] rail_hist;
		logic [3:0][7:0][16:0] shunt_hist;
		logic [3:0][55:0] channel_energy_sum;
		logic [3:0][55:0] energy_snap;
		logic [3:0][31:0] cnt;
		logic [3:0][31:0] cnt_snap;
		logic [7:0] alert_stat;
		logic [7:0] cc_cnt;
		logic alert_n;
		logic sleep;
		pas_conv_req_t conv;
		pas_apb_rsp_t apb;
	} pas_state_t;
endpackage : pas_pkg
`default_nettype wire

//--- hdl/pas_top.sv
// power accumulator sequencer: round robin control, accumulation, alerts, apb registers
//
// Added by the designer: register access over APB and the address map.
`include "pas_consts.svh"
`default_nettype none
module pas_top #(
	parameter int unsigned PERIOD_CYC = `PAS_PERIOD_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire pas_pkg::pas_apb_req_t apb_i,
	output var pas_pkg::pas_apb_rsp_t apb_o,
	output var pas_pkg::pas_conv_req_t conv_o,
	input wire pas_pkg::pas_conv_rsp_t conv_i,
	output logic alert_n_o,
	output logic sleep_o
);
	import pas_pkg::*;

	localparam logic [31:0] PERIOD_LAST = 32'(PERIOD_CYC - 1);
	localparam logic [7:0] CC_CYC = 8'(`PAS_CC_CYC);

	pas_state_t q;
	pas_state_t d;

	// first enabled channel at or above from; offset or done slot otherwise
	function automatic logic [2:0] next_chan(input logic [2:0] from, input logic [3:0] en,
		input logic skip_off);
		logic [2:0] r;
		r = skip_off ? `PAS_DONE_CHAN : `PAS_OFFSET_CHAN;
		for (int i = 3; i >= 0; i--) begin
			if (en[i] && (3'(i) >= from)) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : next_chan

	// left-aligned magnitude against a fullness threshold
	function automatic logic fill_hit(input logic [55:0] m, input logic [1:0] thr);
		case (thr)
			2'h1: return &m[55:52]; // RULE9
			2'h2: return &m[55:53];
			2'h3: return &m[55:54];
			default: return &m;
		endcase
	endfunction : fill_hit

	// signed add that clamps at either end
	function automatic logic [55:0] sat_add(input logic [55:0] a, input logic [55:0] b);
		logic [56:0] s;
		s = {a[55], a} + {b[55], b};
		if (s[56] != s[55]) begin
			return s[56] ? {1'b1, 55'h0} : {1'b0, {55{1'b1}}}; // RULE8
		end
		return s[55:0];
	endfunction : sat_add

	// readable form of an internal sample
	function automatic logic [15:0] fmt(input logic [16:0] v, input logic bip);
		if (bip) begin
			return v[16:1]; // RULE4 RULE5
		end
		return v[16] ? 16'h0000 : v[15:0]; // RULE3
	endfunction : fmt

	// mean of the last eight samples
	function automatic logic [16:0] avg8(input logic [7:0][16:0] h);
		logic [19:0] s;
		s = '0;
		for (int i = 0; i < 8; i++) begin
			s = s + {{3{h[i][16]}}, h[i]};
		end
		return s[19:3]; // RULE13
	endfunction : avg8

	logic wr_done;
	logic rd_done;
	logic prep;
	logic go;
	logic eoc;
	logic burst;
	logic [1:0] ch;
	logic [2:0] first;
	logic [2:0] nxt;
	logic [16:0] rv;
	logic [16:0] sv;
	logic [30:0] pwr;
	logic [55:0] addv;
	logic [55:0] mag;
	logic [31:0] rdata;
	logic rd_err;
	logic [2:0] rch;

	// register read decode
	always_comb begin
		rdata = 32'h0;
		rd_err = 1'b0;
		rch = apb_i.paddr[7:5] - 3'h1;
		if (apb_i.paddr == `PAS_CTRL_ADDR) begin
			rdata[`PAS_CTRL_MODE_LSB +: 3] = q.mode;
			rdata[`PAS_CTRL_CHEN_LSB +: 4] = q.chan_en;
			rdata[`PAS_CTRL_RAILBIP_BIT] = q.rail_bip;
			rdata[`PAS_CTRL_SHUNTBIP_BIT] = q.shunt_bip;
			rdata[`PAS_CTRL_HALF_BIT] = q.half_range_mode;
			rdata[`PAS_CTRL_CCEN_BIT] = q.cc_en;
		end else if (apb_i.paddr == `PAS_ACCCFG_ADDR) begin
			rdata[7:0] = q.acc_sel;
			rdata[`PAS_ACCCFG_THR_LSB +: 8] = q.fill_thr;
		end else if (apb_i.paddr == `PAS_CMD_ADDR) begin
			rdata = 32'h0;
		end else if (apb_i.paddr == `PAS_STATUS_ADDR) begin
			rdata = {22'h0, q.sleep, ~q.alert_n, q.alert_stat};
		end else if (apb_i.paddr[11:5] >= `PAS_CH_FIRST && apb_i.paddr[11:5] <= `PAS_CH_LAST
			&& apb_i.paddr[1:0] == 2'h0) begin
			case (apb_i.paddr[4:2])
				3'h0: rdata[15:0] = fmt(q.rail_voltage_sample[rch[1:0]], q.rail_bip);
				3'h1: rdata[15:0] = fmt(q.shunt_voltage_sample[rch[1:0]], q.shunt_bip);
				3'h2: rdata[15:0] = fmt(avg8(q.rail_hist[rch[1:0]]), q.rail_bip); // RULE21
				3'h3: rdata[15:0] = fmt(avg8(q.shunt_hist[rch[1:0]]), q.shunt_bip);
				3'h4: rdata = q.energy_snap[rch[1:0]][31:0];
				3'h5: rdata = {8'h0, q.energy_snap[rch[1:0]][55:32]};
				3'h6: rdata = q.cnt_snap[rch[1:0]];
				default: rd_err = 1'b1;
			endcase
		end else begin
			rd_err = 1'b1;
		end
	end

	// next state of the whole block
	always_comb begin
		d = q;
		go = 1'b0;
		eoc = 1'b0;
		ch = q.chan[1:0];
		nxt = `PAS_DONE_CHAN;
		rv = conv_i.rail - q.off_rail;
		sv = conv_i.shunt - q.off_shunt;
		burst = (q.mode == PAS_BURST);
		first = next_chan(3'h0, q.chan_en, burst);
		pwr = '0;
		addv = '0;
		mag = '0;
		wr_done = apb_i.psel && apb_i.penable && q.apb.pready;
		rd_done = wr_done && !apb_i.pwrite;
		prep = apb_i.psel && apb_i.penable && !q.apb.pready;
		d.conv.start = 1'b0;
		d.period_cnt = q.period_cnt + 32'h1;
		d.cc_cnt = (q.cc_cnt != 8'h0) ? q.cc_cnt - 8'h1 : 8'h0;

		// apb: one wait cycle, answer prepared from the registers
		d.apb.pready = prep;
		d.apb.pslverr = prep && rd_err;
		if (prep) begin
			d.apb.prdata = apb_i.pwrite ? 32'h0 : rdata;
		end

		// status clears on a completed read
		if (rd_done && apb_i.paddr == `PAS_STATUS_ADDR) begin
			d.alert_stat = 8'h0;
		end

		// register writes take effect at the completing edge
		if (wr_done && apb_i.pwrite) begin
			if (apb_i.paddr == `PAS_CTRL_ADDR) begin
				d.mode = pas_mode_t'(apb_i.pwdata[`PAS_CTRL_MODE_LSB +: 3]);
				d.chan_en = apb_i.pwdata[`PAS_CTRL_CHEN_LSB +: 4]; // RULE15
				d.rail_bip = apb_i.pwdata[`PAS_CTRL_RAILBIP_BIT];
				d.shunt_bip = apb_i.pwdata[`PAS_CTRL_SHUNTBIP_BIT];
				d.half_range_mode = apb_i.pwdata[`PAS_CTRL_HALF_BIT];
				d.cc_en = apb_i.pwdata[`PAS_CTRL_CCEN_BIT];
			end
			if (apb_i.paddr == `PAS_ACCCFG_ADDR) begin
				d.acc_sel = apb_i.pwdata[7:0]; // RULE11
				d.fill_thr = apb_i.pwdata[`PAS_ACCCFG_THR_LSB +: 8];
			end
			if (apb_i.paddr == `PAS_CMD_ADDR && apb_i.pwdata[`PAS_CMD_SNAP_BIT]) begin
				// snapshot and restart the sums; a sample landing now adds to the fresh sum
				d.energy_snap = q.channel_energy_sum;
				d.cnt_snap = q.cnt;
				d.channel_energy_sum = '0;
				d.cnt = '0;
				if (q.seq == PAS_SLEEP && q.chan_en != 4'h0
					&& (q.mode == PAS_SINGLE || q.mode == PAS_SINGLE8)) begin
					go = 1'b1; // RULE18
					d.shots = (q.mode == PAS_SINGLE8) ? `PAS_SHOTS_8X : 4'h1; // RULE20
				end
			end
		end

		// round robin sequencer
		case (q.seq)
			PAS_SLEEP: begin
				if (q.chan_en != 4'h0 && (q.mode == PAS_CONT || q.mode == PAS_BURST
					|| q.mode == PAS_FAST)) begin
					go = 1'b1;
				end
			end
			PAS_START: begin
				d.conv.start = 1'b1;
				d.conv.chan = q.chan;
				d.seq = PAS_WAIT;
			end
			PAS_WAIT: begin
				if (conv_i.done) begin
					if (q.chan == `PAS_OFFSET_CHAN) begin
						d.off_rail = conv_i.rail;
						d.off_shunt = conv_i.shunt;
					end else begin
						// full 17-bit shunt times 14 rail bits; half range shifts one up
						if (q.half_range_mode) begin
							pwr = 31'($signed(sv) * $signed(rv[15:2])); // RULE6
						end else begin
							pwr = 31'($signed(sv) * $signed(rv[16:3])); // RULE1 RULE2
						end
						case (q.acc_sel[ch])
							2'h1: addv = {{39{sv[16]}}, sv}; // RULE11
							2'h2: addv = {{39{rv[16]}}, rv};
							default: addv = {{26{pwr[29]}}, pwr[29:0]}; // RULE10
						endcase
						d.rail_voltage_sample[ch] = rv;
						d.shunt_voltage_sample[ch] = sv;
						d.rail_hist[ch] = {q.rail_hist[ch][6:0], rv}; // RULE13
						d.shunt_hist[ch] = {q.shunt_hist[ch][6:0], sv};
						d.channel_energy_sum[ch] = sat_add(d.channel_energy_sum[ch], addv); // RULE12
						if (d.cnt[ch] != 32'hFFFFFFFF) begin
							d.cnt[ch] = d.cnt[ch] + 32'h1; // RULE7
						end
					end
					nxt = (q.chan == `PAS_OFFSET_CHAN) ? `PAS_DONE_CHAN
						: next_chan(q.chan + 3'h1, q.chan_en, burst); // RULE14 RULE16
					if (nxt != `PAS_DONE_CHAN) begin
						d.chan = nxt;
						d.seq = PAS_START;
					end else begin
						eoc = 1'b1;
						case (q.mode)
							PAS_SINGLE8: begin
								if (q.shots > 4'h1 && q.chan_en != 4'h0) begin
									d.shots = q.shots - 4'h1; // RULE20
									go = 1'b1;
								end else begin
									d.seq = PAS_SLEEP;
								end
							end
							PAS_SINGLE: d.seq = PAS_SLEEP; // RULE18
							PAS_BURST, PAS_FAST: begin
								// restart at once without a sleep gap
								if (q.chan_en != 4'h0) begin
									go = 1'b1; // RULE16 RULE17
								end else begin
									d.seq = PAS_SLEEP; // RULE15
								end
							end
							default: d.seq = PAS_PAD; // RULE14
						endcase
					end
				end
			end
			PAS_PAD: begin
				// sleep out the rest of the period; rate does not depend on channel count
				if (q.period_cnt >= PERIOD_LAST) begin
					if (q.chan_en != 4'h0) begin
						go = 1'b1;
					end else begin
						d.seq = PAS_SLEEP; // RULE15
					end
				end
			end
			default: d.seq = PAS_SLEEP;
		endcase

		// start a fresh cycle at the first enabled channel
		if (go) begin
			d.seq = PAS_START;
			d.chan = first;
			d.period_cnt = 32'h0;
		end

		// end of cycle: fullness alerts latch, set beats a same-cycle clear
		if (eoc) begin
			for (int c = 0; c < 4; c++) begin
				mag = {d.channel_energy_sum[c][55] ? ~d.channel_energy_sum[c][54:0]
					: d.channel_energy_sum[c][54:0], 1'b1};
				if (fill_hit(mag, q.fill_thr[c])) begin
					d.alert_stat[c] = 1'b1; // RULE9 RULE22
				end
				if (fill_hit({d.cnt[c], 24'hFFFFFF}, q.fill_thr[c])) begin
					d.alert_stat[4 + c] = 1'b1; // RULE9
				end
			end
			if (q.cc_en && !(burst && $countones(q.chan_en) == 1)) begin
				d.cc_cnt = CC_CYC; // RULE22
			end
		end

		d.alert_n = !((d.alert_stat != 8'h0) || (d.cc_cnt != 8'h0)); // RULE22
		d.sleep = (d.seq == PAS_SLEEP);
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			q <= '0;
			q.mode <= pas_mode_t'(3'(`PAS_CTRL_RST >> `PAS_CTRL_MODE_LSB));
			q.chan_en <= 4'(`PAS_CTRL_RST >> `PAS_CTRL_CHEN_LSB);
			q.seq <= PAS_SLEEP;
			q.alert_n <= 1'b1;
			q.sleep <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state flops
	assign apb_o = q.apb;
	assign conv_o = q.conv;
	assign alert_n_o = q.alert_n;
	assign sleep_o = q.sleep;
endmodule : pas_top
`default_nettype wire

//--- sim/pas_conv_model.sv
// behavioural converter answering the sequencer's slot requests
`default_nettype none
module pas_conv_model (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire pas_pkg::pas_conv_req_t req_i,
	input wire logic [4:0][16:0] rail_i,
	input wire logic [4:0][16:0] shunt_i,
	input wire logic [4:0] delay_i,
	output var pas_pkg::pas_conv_rsp_t rsp_o
);
	import pas_pkg::*;
	int cnt;
	logic [2:0] ch;
	// latency counts down from each request; data toggle when not valid
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt <= 0;
			ch <= 3'h0;
			rsp_o <= '0;
		end else if (req_i.start) begin
			cnt <= delay_i + 1;
			ch <= req_i.chan;
			rsp_o.done <= 1'b0;
		end else if (cnt == 1) begin
			cnt <= 0;
			rsp_o <= '{1'b1, rail_i[ch], shunt_i[ch]};
		end else begin
			if (cnt > 1) cnt <= cnt - 1;
			rsp_o <= '{1'b0, ~rsp_o.rail, ~rsp_o.shunt}; // stale data flips to its inverse every cycle
		end
	end
endmodule : pas_conv_model
`default_nettype wire

//--- sim/pas_top_chk.sv
// port assertions for the power accumulator sequencer
`default_nettype none
module pas_top_chk #(
	parameter int unsigned PERIOD_CYC = 200
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire pas_pkg::pas_apb_req_t apb_i,
	input wire pas_pkg::pas_apb_rsp_t apb_o,
	input wire pas_pkg::pas_conv_req_t conv_o,
	input wire pas_pkg::pas_conv_rsp_t conv_i,
	input wire logic alert_n_o,
	input wire logic sleep_o
);
	import pas_pkg::*;
	logic pend_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// tracks an outstanding converter request
	always_ff @(posedge clk_i) begin
		if (!resetn_i) pend_q <= 1'b0;
		else if (conv_o.start) pend_q <= 1'b1;
		else if (conv_i.done) pend_q <= 1'b0;
	end
	chk_one_pending: assert property (conv_o.start |-> !pend_q)
		else $error("converter request while one is pending");
	chk_start_pulse: assert property (conv_o.start |=> !conv_o.start [*2])
		else $error("converter start pulses too close");
	chk_chan_hold: assert property (!conv_o.start |-> $stable(conv_o.chan))
		else $error("slot number moved without a request");
	chk_chan_range: assert property (conv_o.start |-> conv_o.chan <= 3'h4)
		else $error("slot number out of range");
	chk_sleep_quiet: assert property (sleep_o |-> !conv_o.start)
		else $error("request issued while asleep");
	chk_wake_start: assert property ($fell(sleep_o) |-> ##[0:3] conv_o.start)
		else $error("wake without a conversion request");
	chk_alert_cause: assert property ($fell(alert_n_o) |->
		$past(conv_i.done) || $past(conv_i.done, 2))
		else $error("alert fell away from a cycle end");
	chk_alert_width: assert property ($fell(alert_n_o) |-> !alert_n_o [*8])
		else $error("alert pulse too short");
	chk_ready_wait: assert property (apb_i.psel && apb_i.penable && !apb_o.pready
		|=> apb_o.pready)
		else $error("ready not given after one wait state");
	chk_ready_only: assert property (apb_o.pready |-> apb_i.psel && apb_i.penable)
		else $error("ready outside an access");
	chk_err_ready: assert property (apb_o.pslverr |-> apb_o.pready)
		else $error("error without ready");
	cover property (conv_o.start && conv_o.chan == 3'h4);
	cover property ($fell(alert_n_o));
	cover property ($rose(sleep_o));
	cover property (apb_o.pready && apb_o.pslverr);
endmodule : pas_top_chk
bind pas_top pas_top_chk #(.PERIOD_CYC(PERIOD_CYC)) i_chk (.clk_i(clk_i),
	.resetn_i(resetn_i), .apb_i(apb_i), .apb_o(apb_o), .conv_o(conv_o), .conv_i(conv_i),
	.alert_n_o(alert_n_o), .sleep_o(sleep_o));
`default_nettype wire

//--- sim/power_accumulator_sequencer_tb.sv
// self-checking bench of the power accumulator sequencer
`include "pas_consts.svh"
`default_nettype none
module power_accumulator_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pas_pkg::*;
	localparam int PER = 200;
	localparam int GAP = 50000; // two ms at 25 MHz
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	pas_apb_req_t apb_i = '0;
	pas_apb_rsp_t apb_o;
	pas_conv_req_t conv_o;
	pas_conv_rsp_t conv_i;
	logic alert_n_o;
	logic sleep_o;
	logic [4:0][16:0] rail;
	logic [4:0][16:0] shunt;
	logic [4:0] dly = 5'h03;
	int seed = 67601;
	int dseed = 67601;
	int fails = 0;
	int comparisons = 0;
	logic [2:0] seen[$];
	logic coll = 1'b0;
	logic slept = 1'b0;
	logic alerted = 1'b0;
	logic [2:0] first = 3'h0;
	logic [31:0] rd;
	logic err;
	// 25 MHz clock
	initial forever #20 clk_i = ~clk_i;
	pas_top #(.PERIOD_CYC(PER)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb_i),
		.apb_o(apb_o), .conv_o(conv_o), .conv_i(conv_i), .alert_n_o(alert_n_o),
		.sleep_o(sleep_o));
	pas_conv_model i_conv (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(conv_o), .rail_i(rail),
		.shunt_i(shunt), .delay_i(dly), .rsp_o(conv_i));
	// random converter latency; slot order, sleep and alert capture while collecting
	always @(posedge clk_i) begin
		dly <= 5'($random(dseed));
		if (!coll) begin
			seen.delete();
			slept <= 1'b0;
			alerted <= 1'b0;
		end else begin
			if (conv_o.start === 1'b1 && (seen.size() > 0 || conv_o.chan === first))
				seen.push_back(conv_o.chan);
			if (sleep_o === 1'b1) slept <= 1'b1;
			if (alert_n_o === 1'b0) alerted <= 1'b1;
		end
	end
	function automatic logic [16:0] cor(input int c, input logic r);
		return r ? rail[c] - rail[4] : shunt[c] - shunt[4];
	endfunction : cor
	function automatic logic [55:0] accv(input int c, input logic [1:0] s, input logic h);
		logic signed [16:0] sv;
		logic signed [16:0] rv;
		logic signed [29:0] p;
		sv = cor(c, 1'b0);
		rv = cor(c, 1'b1);
		p = h ? sv * $signed(rv[15:2]) : sv * $signed(rv[16:3]); // half range: one bit lower
		return s == 2'h1 ? 56'(sv) : (s == 2'h2 ? 56'(rv) : 56'(p));
	endfunction : accv
	function automatic logic [15:0] fmt(input logic [16:0] v, input logic b);
		return b ? v[16:1] : (v[16] ? 16'h0000 : v[15:0]);
	endfunction : fmt
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
			fails++;
		end
	endtask : chk
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apb_i <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (apb_o.pready !== 1'b1 && n < 50);
		rd = apb_o.prdata;
		err = apb_o.pslverr;
		apb_i <= '0;
		@(posedge clk_i);
		if (n >= 50) begin
			fails++;
			finish_test();
		end
	endtask : bus
	task automatic run_seq(input logic [2:0] m, input logic [3:0] en);
		logic [2:0] ex[$];
		int n;
		for (int c = 0; c < 4; c++) if (en[c]) ex.push_back(3'(c));
		if (m != 3'h1) ex.push_back(3'h4);
		bus(1'b1, `PAS_CTRL_ADDR, {20'h0, 4'h8, en, 1'b0, m});
		repeat (3 * PER) @(posedge clk_i);
		first = ex[0];
		coll <= 1'b1;
		for (n = 0; n < 40 * PER && seen.size() < 2 * ex.size(); n++) @(posedge clk_i);
		coll <= 1'b0;
		if (n >= 40 * PER) begin
			fails++;
			finish_test();
		end
		foreach (ex[i]) begin
			chk(32'(seen[i]), 32'(ex[i]));
			chk(32'(seen[i + ex.size()]), 32'(ex[i]));
		end
		if (m != 3'h0) chk(32'(slept), 32'h0);
		chk(32'(alerted), 32'(!(m == 3'h1 && $countones(en) == 1)));
		$display("test slot order mode %0d channels %h done", m, en);
	endtask : run_seq
	// main sequence
	initial begin
		logic [55:0] sum;
		logic [11:0] base;
		logic [3:0] e;
		logic [31:0] got;
		int n;
		for (int c = 0; c < 5; c++) begin
			rail[c] = 17'($random(seed));
			shunt[c] = 17'($random(seed));
		end
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		bus(1'b0, `PAS_CTRL_ADDR, 32'h0);
		chk(rd, `PAS_CTRL_RST);
		bus(1'b0, `PAS_ACCCFG_ADDR, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 12'h03C, 32'h0);
		chk(32'(err), 32'h1);
		$display("test register reset done");
		run_seq(3'h0, 4'hF);
		run_seq(3'h1, 4'h4);
		for (int k = 0; k < 4; k++) begin
			e = 4'($random(seed));
			run_seq(3'(1 + k % 2), e == 4'h0 ? 4'h9 : e);
		end
		// continuous half range run with mixed sources; the snapshot restarts the sums
		bus(1'b1, `PAS_ACCCFG_ADDR, 32'h000000E4);
		bus(1'b1, `PAS_CTRL_ADDR, 32'h000004F0);
		repeat (3 * PER) @(posedge clk_i);
		bus(1'b1, `PAS_CMD_ADDR, 32'h1);
		repeat (GAP / 2) @(posedge clk_i);
		bus(1'b1, `PAS_CTRL_ADDR, 32'h00000400);
		for (n = 0; n < 20 * PER && sleep_o !== 1'b1; n++) @(posedge clk_i);
		chk(32'(sleep_o), 32'h1);
		bus(1'b1, `PAS_CTRL_ADDR, 32'h000000F4);
		repeat (PER) @(posedge clk_i);
		chk(32'(sleep_o), 32'h1);
		bus(1'b1, `PAS_CMD_ADDR, 32'h1);
		// this snapshot holds the half range run, where every sample is the same
		for (int c = 0; c < 4; c++) begin
			base = 12'h020 + 12'(c) * 12'h020;
			bus(1'b0, base + 12'h018, 32'h0);
			got = rd;
			chk(32'(got != 32'h0), 32'h1);
			sum = 56'(got) * accv(c, 2'(c), 1'b1);
			bus(1'b0, base + 12'h010, 32'h0);
			chk(rd, sum[31:0]);
			bus(1'b0, base + 12'h014, 32'h0);
			chk(rd, {8'h00, sum[55:32]});
		end
		$display("test half range accumulation done");
		repeat (GAP) @(posedge clk_i);
		chk(32'(sleep_o), 32'h1);
		bus(1'b0, `PAS_STATUS_ADDR, 32'h0);
		chk(rd, 32'h00000200);
		chk(32'(alert_n_o), 32'h1);
		bus(1'b1, `PAS_CMD_ADDR, 32'h1);
		for (int c = 0; c < 4; c++) begin
			sum = accv(c, 2'(c), 1'b0) << 3;
			base = 12'h020 + 12'(c) * 12'h020;
			bus(1'b0, base + 12'h018, 32'h0);
			chk(rd, 32'h8);
			bus(1'b0, base + 12'h010, 32'h0);
			chk(rd, sum[31:0]);
			bus(1'b0, base + 12'h014, 32'h0);
			chk(rd, {8'h00, sum[55:32]});
			for (int b = 0; b < 4; b++) begin
				bus(1'b1, `PAS_CTRL_ADDR, 32'h000000F4 | 32'(b << 8));
				bus(1'b0, base, 32'h0);
				chk(32'(rd[15:0]), 32'(fmt(cor(c, 1'b1), b[0])));
				bus(1'b0, base + 12'h004, 32'h0);
				chk(32'(rd[15:0]), 32'(fmt(cor(c, 1'b0), b[1])));
				bus(1'b0, base + 12'h008, 32'h0);
				chk(32'(rd[15:0]), 32'(fmt(cor(c, 1'b1), b[0])));
				bus(1'b0, base + 12'h00C, 32'h0);
				chk(32'(rd[15:0]), 32'(fmt(cor(c, 1'b0), b[1])));
			end
		end
		$display("test single 8X accumulation done");
		finish_test();
	end
endmodule : power_accumulator_sequencer_tb
`default_nettype wire
